// file: logic/tpfp_pkg.sv
// constants for the telemetry payload frame packer
package tpfp_pkg;
   // frame geometry
   localparam int FRAME_BITS        = 458;
   localparam int POS_W             = 9;
   localparam int PAYLOAD_TYPE_W    = 8;
   localparam logic [7:0] MAX_PAYLOAD_TYPE = 8'h02;
   localparam int CHAN_W            = 12;
   localparam int NUM_CHAN          = 32;
   localparam int CHAN_SEL_W        = 5;
   localparam int CHAN_TOP          = 383;
   localparam int PANEL_V_BASE      = 96;
   localparam int PANEL_V_LAST      = 156;
   localparam int SPIN_OFS          = 252;
   localparam int SPIN_SIGN         = 11;
   localparam int HARD_ERR_OFS      = 384;
   localparam int HARD_ERR_W        = 32;
   localparam int TS_RESETS_OFS     = 416;
   localparam int TS_RESETS_W       = 16;
   localparam int TS_UPTIME_OFS     = 432;
   localparam int TS_UPTIME_W       = 25;
   localparam int SAFE_OFS          = 457;
   // closing status fields of the real-time frame
   localparam int RT_TAIL_BASE      = 416;
   localparam int RT_TAIL_W         = 13;
   localparam int RT_EXP_OFS        = 416;
   localparam int RT_EXP_W          = 4;
   localparam int RT_BUS_OFS        = 420;
   localparam int RT_BUS_W          = 3;
   localparam int RT_TLMRST_OFS     = 423;
   localparam int RT_TLMRST_W       = 4;
   localparam int RT_ANT_OFS        = 427;
   localparam int RT_ANT_W          = 2;
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h0c;
   localparam logic [7:0] REG_RT_TAIL   = 8'h10;
   localparam logic [7:0] REG_TS_RESETS = 8'h14;
   localparam logic [7:0] REG_TS_UPTIME = 8'h18;
   localparam int CTRL_START        = 0;
   localparam int CTRL_CLEAR        = 1;
   localparam int IRQ_W             = 3;
   localparam int IRQ_NEW_MAX       = 0;
   localparam int IRQ_FRAME_DONE    = 1;
   localparam int IRQ_REFUSED       = 2;
   localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
   localparam logic [11:0] CHAN_RST     = 12'h000;
endpackage : tpfp_pkg

// file: logic/tpfp_frame_packer.sv
// maximum-values frame packer with real-time status tail and register port
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module tpfp_frame_packer (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [31:0] reg_rdata,
   input  wire logic        smp_valid,
   input  wire logic [4:0]  smp_chan,
   input  wire logic [11:0] smp_value,
   input  wire logic [15:0] reset_count,
   input  wire logic [24:0] uptime_s,
   input  wire logic [31:0] hard_err,
   input  wire logic        safe_mode,
   input  wire logic [3:0]  exp_fail,
   input  wire logic [2:0]  bus_fail,
   input  wire logic [3:0]  tlm_resets,
   input  wire logic [1:0]  ant_deployed,
   output logic      [12:0] rt_tail,
   output logic      [7:0]  payload_type,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic             tx_bit,
   output logic             tx_last,
   output logic             irq
);
   typedef enum logic [1:0] {
      TPFP_IDLE = 2'b01,
      TPFP_SEND = 2'b10
   } tpfp_state_t;

   // sign-magnitude to two's complement for the spin channel
   function automatic logic signed [12:0] tpfp_sm_to_int(input logic [11:0] v);
      logic signed [12:0] mag;
      mag = $signed({2'b00, v[10:0]});
      return v[tpfp_pkg::SPIN_SIGN] ? -mag : mag;
   endfunction

   function automatic logic tpfp_exceeds(input logic [4:0] chan, input logic [11:0] nv,
                                         input logic [11:0] ov);
      logic spin;
      spin = (32'(chan) * tpfp_pkg::CHAN_W) == tpfp_pkg::SPIN_OFS;
      if (spin) begin
         return tpfp_sm_to_int(nv) > tpfp_sm_to_int(ov);
      end
      return nv > ov;
   endfunction

   // ---------------- maxima store ----------------
   logic [11:0] max_q [tpfp_pkg::NUM_CHAN];
   logic [11:0] max_d [tpfp_pkg::NUM_CHAN];
   logic [15:0] ts_resets_q, ts_resets_d;
   logic [24:0] ts_uptime_q, ts_uptime_d;
   logic        clear_req;
   logic        new_max;
   logic [11:0] base_val;

   always_comb begin
      max_d       = max_q;
      ts_resets_d = ts_resets_q;
      ts_uptime_d = ts_uptime_q;
      if (clear_req) begin
         for (int c = 0; c < tpfp_pkg::NUM_CHAN; c++) begin
            max_d[c] = tpfp_pkg::CHAN_RST;
         end
         ts_resets_d = '0;
         ts_uptime_d = '0;
      end
      // a sample in the clearing cycle is judged against the cleared value
      base_val = clear_req ? tpfp_pkg::CHAN_RST : max_q[smp_chan];
      new_max  = smp_valid && tpfp_exceeds(smp_chan, smp_value, base_val);
      if (new_max) begin
         max_d[smp_chan] = smp_value;
         ts_resets_d     = reset_count;
         ts_uptime_d     = uptime_s;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int c = 0; c < tpfp_pkg::NUM_CHAN; c++) begin
            max_q[c] <= tpfp_pkg::CHAN_RST;
         end
         ts_resets_q <= '0;
         ts_uptime_q <= '0;
      end else begin
         max_q       <= max_d;
         ts_resets_q <= ts_resets_d;
         ts_uptime_q <= ts_uptime_d;
      end
   end

   // ---------------- real-time status tail ----------------
   logic [12:0] rt_tail_q, rt_tail_d;

   always_comb begin
      rt_tail_d = '0;
      rt_tail_d[tpfp_pkg::RT_EXP_OFS-tpfp_pkg::RT_TAIL_BASE +: tpfp_pkg::RT_EXP_W] =
         exp_fail;
      rt_tail_d[tpfp_pkg::RT_BUS_OFS-tpfp_pkg::RT_TAIL_BASE +: tpfp_pkg::RT_BUS_W] =
         bus_fail;
      rt_tail_d[tpfp_pkg::RT_TLMRST_OFS-tpfp_pkg::RT_TAIL_BASE +: tpfp_pkg::RT_TLMRST_W] =
         tlm_resets;
      rt_tail_d[tpfp_pkg::RT_ANT_OFS-tpfp_pkg::RT_TAIL_BASE +: tpfp_pkg::RT_ANT_W] =
         ant_deployed;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rt_tail_q <= '0;
      end else begin
         rt_tail_q <= rt_tail_d;
      end
   end
   assign rt_tail = rt_tail_q;

   // ---------------- frame serialiser ----------------
   tpfp_state_t state_q, state_d;
   logic [tpfp_pkg::FRAME_BITS-1:0] shreg_q, shreg_d, frame_v;
   logic [8:0]  pos_q, pos_d;
   logic [7:0]  ptype_q, ptype_d;
   logic        start_req;
   logic        start_go;
   logic        refused;
   logic        frame_done;
   logic        at_end;

   always_comb begin
      frame_v = '0;
      for (int c = 0; c < tpfp_pkg::NUM_CHAN; c++) begin
         frame_v[c*tpfp_pkg::CHAN_W +: tpfp_pkg::CHAN_W] = max_q[c];
      end
      frame_v[tpfp_pkg::HARD_ERR_OFS +: tpfp_pkg::HARD_ERR_W]   = hard_err;
      frame_v[tpfp_pkg::TS_RESETS_OFS +: tpfp_pkg::TS_RESETS_W] = ts_resets_q;
      frame_v[tpfp_pkg::TS_UPTIME_OFS +: tpfp_pkg::TS_UPTIME_W] = ts_uptime_q;
      frame_v[tpfp_pkg::SAFE_OFS] = safe_mode;
   end

   assign at_end     = pos_q == 9'(tpfp_pkg::FRAME_BITS - 1);
   assign start_go   = start_req && (state_q == TPFP_IDLE);
   assign refused    = start_req && (state_q != TPFP_IDLE);
   assign tx_valid   = state_q == TPFP_SEND;
   assign tx_last    = tx_valid && at_end;
   assign frame_done = tx_last && tx_ready;

   always_comb begin
      state_d = state_q;
      shreg_d = shreg_q;
      pos_d   = pos_q;
      ptype_d = ptype_q;
      case (state_q)
         TPFP_IDLE: begin
            if (start_go) begin
               // snapshot keeps the frame coherent while maxima keep moving
               shreg_d = frame_v;
               pos_d   = '0;
               ptype_d = tpfp_pkg::MAX_PAYLOAD_TYPE;
               state_d = TPFP_SEND;
            end
         end
         TPFP_SEND: begin
            if (tx_ready) begin
               shreg_d = {1'b0, shreg_q[tpfp_pkg::FRAME_BITS-1:1]};
               pos_d   = pos_q + 9'h001;
               if (at_end) begin
                  state_d = TPFP_IDLE;
               end
            end
         end
         default: begin
            state_d = TPFP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= TPFP_IDLE;
         shreg_q <= '0;
         pos_q   <= '0;
         ptype_q <= '0;
      end else begin
         state_q <= state_d;
         shreg_q <= shreg_d;
         pos_q   <= pos_d;
         ptype_q <= ptype_d;
      end
   end
   assign tx_bit       = shreg_q[0];
   assign payload_type = ptype_q;

   // ---------------- register port and interrupts ----------------
   logic [2:0]  mask_q, mask_d;
   logic [2:0]  istat_q, istat_d;
   logic [31:0] rdata_q, rdata_d;
   logic [2:0]  events;
   logic        wr_ctrl;

   assign wr_ctrl   = reg_we && (reg_addr == tpfp_pkg::REG_CTRL);
   assign start_req = wr_ctrl && reg_wdata[tpfp_pkg::CTRL_START];
   assign clear_req = wr_ctrl && reg_wdata[tpfp_pkg::CTRL_CLEAR];

   always_comb begin
      events = '0;
      events[tpfp_pkg::IRQ_NEW_MAX]    = new_max;
      events[tpfp_pkg::IRQ_FRAME_DONE] = frame_done;
      events[tpfp_pkg::IRQ_REFUSED]    = refused;
      mask_d = mask_q;
      if (reg_we && (reg_addr == tpfp_pkg::REG_IRQ_MASK)) begin
         mask_d = reg_wdata[2:0];
      end
      // an event in the clearing read survives it
      istat_d = events;
      if (!(reg_re && (reg_addr == tpfp_pkg::REG_IRQ_STAT))) begin
         istat_d = istat_q | events;
      end
      rdata_d = '0;
      if (reg_re) begin
         case (reg_addr)
            tpfp_pkg::REG_STATUS:    rdata_d = {30'h0, safe_mode, tx_valid};
            tpfp_pkg::REG_IRQ_STAT:  rdata_d = {29'h0, istat_q};
            tpfp_pkg::REG_IRQ_MASK:  rdata_d = {29'h0, mask_q};
            tpfp_pkg::REG_RT_TAIL:   rdata_d = {19'h0, rt_tail_q};
            tpfp_pkg::REG_TS_RESETS: rdata_d = {16'h0, ts_resets_q};
            tpfp_pkg::REG_TS_UPTIME: rdata_d = {7'h0, ts_uptime_q};
            default:                 rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mask_q  <= tpfp_pkg::IRQ_MASK_RST;
         istat_q <= '0;
         rdata_q <= '0;
      end else begin
         mask_q  <= mask_d;
         istat_q <= istat_d;
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;
   assign irq       = |(istat_q & mask_q);

   // ---------------- assertions ----------------
   default clocking tpfp_cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   logic [11:0] sel_max;
   assign sel_max = max_q[smp_chan];

   sequence s_frame_start;
      start_go;
   endsequence

   sequence s_first_bit;
      tx_valid && (pos_q == 9'h000) && (payload_type == tpfp_pkg::MAX_PAYLOAD_TYPE);
   endsequence

   AST_FRAME_OPENS:
   assert property (s_frame_start |=> s_first_bit)
      else $error("frame did not open at bit zero with type two");

   AST_LAST_AT_457:
   assert property (tx_valid && tx_ready && tx_last |=> !tx_valid && $past(pos_q) == 9'h1c9)
      else $error("frame did not end after bit 457");

   AST_SAFE_BIT:
   assert property (s_frame_start |=> shreg_q[tpfp_pkg::SAFE_OFS] == $past(safe_mode))
      else $error("safe mode bit not at the frame end");

   AST_PANEL_LAST:
   assert property (s_frame_start |=> shreg_q[tpfp_pkg::PANEL_V_LAST +: 12] == $past(max_q[13]))
      else $error("last panel voltage misplaced");

   AST_PANEL_FIRST:
   assert property (s_frame_start |=> shreg_q[tpfp_pkg::PANEL_V_BASE +: 12] == $past(max_q[8]))
      else $error("first panel voltage misplaced");

   AST_TIMESTAMPS:
   // the channel may change on the next sample, so the stored slot is looked up by the old one
   assert property (new_max |=> ts_resets_q == $past(reset_count) &&
                                ts_uptime_q == $past(uptime_s) &&
                                max_q[$past(smp_chan)] == $past(smp_value))
      else $error("new maximum did not latch value and timestamp");

   AST_KEEP_MAX:
   assert property (smp_valid && !clear_req && smp_value <= sel_max &&
                    smp_chan != 5'h15 |=> $stable(ts_uptime_q))
      else $error("smaller sample moved the timestamp");

   AST_SPIN_SIGN:
   assert property (smp_valid && !clear_req && smp_chan == 5'h15 && smp_value[11] &&
                    !sel_max[11] && sel_max[10:0] != 11'h000 |-> !new_max)
      else $error("negative spin taken as a new maximum");

   AST_RT_TAIL:
   assert property (1'b1 |=> rt_tail[4 +: 3] == $past(bus_fail) &&
                             rt_tail[7 +: 4] == $past(tlm_resets))
      else $error("bus failure or reset count misplaced");

   AST_RT_ENDS:
   assert property (1'b1 |=> rt_tail[11 +: 2] == $past(ant_deployed) &&
                             rt_tail[3:0] == $past(exp_fail))
      else $error("antenna or experiment bits misplaced");

   AST_SNAP_RESETS:
   assert property (s_frame_start |=> shreg_q[tpfp_pkg::TS_RESETS_OFS +: 16] == $past(ts_resets_q))
      else $error("reset count not at bit 416");

endmodule // tpfp_frame_packer

// file: bench/tpfp_downlink_model.sv
// downlink side model: takes frame bits with random stalls
`timescale 1ns/10ps
module tpfp_downlink_model (
   input  wire logic    clk,
   input  wire logic    nrst,
   input  wire logic    tx_valid,
   input  wire logic    tx_bit,
   input  wire logic    tx_last,
   output logic         tx_ready,
   output logic [457:0] frame_q,
   output int           bit_cnt,
   output logic         done_q
);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_ready <= 1'b0;
         bit_cnt  <= 0;
         done_q   <= 1'b0;
         frame_q  <= '0;
      end else begin
         done_q   <= 1'b0;
         // stall one cycle in four so held bits are exercised
         tx_ready <= ($urandom_range(3) != 0);
         if (tx_valid && tx_ready) begin
            if (bit_cnt < 458) frame_q[bit_cnt] <= tx_bit;
            bit_cnt <= bit_cnt + 1;
            if (tx_last) done_q <= 1'b1;
         end
      end
   end
endmodule // tpfp_downlink_model

// file: bench/tb.sv
// self-checking bench for the telemetry frame packer
`timescale 1ns/10ps
module tb;
   logic         clk = 1'b0;
   logic         nrst = 1'b0;
   logic [7:0]   reg_addr = 8'h00;
   logic [31:0]  reg_wdata = 32'h0;
   logic         reg_we = 1'b0;
   logic         reg_re = 1'b0;
   logic         smp_valid = 1'b0;
   logic [4:0]   smp_chan = 5'h0;
   logic [11:0]  smp_value = 12'h0;
   logic [15:0]  reset_count = 16'h0;
   logic [24:0]  uptime_s = 25'h0;
   logic [31:0]  hard_err = 32'h0;
   logic         safe_mode = 1'b0;
   logic [3:0]   exp_fail = 4'h0;
   logic [2:0]   bus_fail = 3'h0;
   logic [3:0]   tlm_resets = 4'h0;
   logic [1:0]   ant_deployed = 2'h0;
   logic [31:0]  reg_rdata;
   logic [12:0]  rt_tail;
   logic [7:0]   payload_type;
   logic         tx_valid, tx_ready, tx_bit, tx_last, irq, done_q;
   logic [457:0] frame_q;
   logic [11:0]  exp_max [32];
   logic [15:0]  exp_rc, rc;
   logic [24:0]  exp_up, up;
   logic [4:0]   ch;
   logic [11:0]  v;
   logic [31:0]  rd_v;
   int           bit_cnt, error_cnt = 0, comparisons = 0, cyc = 0;

   tpfp_frame_packer u_tpfp_frame_packer (.clk, .nrst, .reg_addr, .reg_wdata, .reg_we,
      .reg_re, .reg_rdata, .smp_valid, .smp_chan, .smp_value, .reset_count, .uptime_s,
      .hard_err, .safe_mode, .exp_fail, .bus_fail, .tlm_resets, .ant_deployed, .rt_tail,
      .payload_type, .tx_valid, .tx_ready, .tx_bit, .tx_last, .irq);
   tpfp_downlink_model u_tpfp_downlink_model (.clk, .nrst, .tx_valid, .tx_bit, .tx_last,
      .tx_ready, .frame_q, .bit_cnt, .done_q);

   always #25 clk = ~clk;
   // whole run is under a thousand cycles; the ceiling leaves wide margin
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] expv);
      comparisons++;
      if (seen !== expv) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task end_sim;
      if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      @(posedge clk);
      reg_we    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_re   <= 1'b1;
      @(posedge clk);
      reg_re   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // signed value of a sign-magnitude spin reading
   function automatic int sm(input logic [11:0] x);
      return x[11] ? -int'(x[10:0]) : int'(x[10:0]);
   endfunction
   // spin is sign-magnitude, so negative values never beat a cleared zero
   function automatic bit bigger(input logic [4:0] c, input logic [11:0] a, input logic [11:0] m);
      if (c == 5'h15)
         return sm(a) > sm(m);
      return a > m;
   endfunction

   initial begin
      void'($urandom(32'hbe55));
      for (int i = 0; i < 32; i++) exp_max[i] = 12'h000;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) begin
         @(posedge clk);
         {ant_deployed, tlm_resets, bus_fail, exp_fail} <= 13'($urandom);
         @(posedge clk);
         #1;
         check(rt_tail[3:0], exp_fail);
         check(rt_tail[6:4], bus_fail);
         check(rt_tail[10:7], tlm_resets);
         check(rt_tail[12:11], ant_deployed);
      end
      rd(tpfp_pkg::REG_RT_TAIL, rd_v);
      check(rd_v, {ant_deployed, tlm_resets, bus_fail, exp_fail});
      wr(tpfp_pkg::REG_IRQ_MASK, 32'h1);
      for (int n = 0; n < 200; n++) begin
         ch = (n < 32) ? 5'(n) : 5'($urandom);
         v  = 12'($urandom);
         rc = 16'($urandom);
         up = 25'($urandom);
         if (n == 198) {ch, v} = {5'h15, 12'hfff};
         if (n == 199) {ch, v} = {5'h03, exp_max[3]};
         @(posedge clk);
         smp_valid   <= 1'b1;
         smp_chan    <= ch;
         smp_value   <= v;
         reset_count <= rc;
         uptime_s    <= up;
         if (bigger(ch, v, exp_max[ch])) begin
            exp_max[ch] = v;
            exp_rc = rc;
            exp_up = up;
         end
      end
      @(posedge clk);
      smp_valid <= 1'b0;
      @(posedge clk);
      #1;
      check(irq, 1'b1);
      rd(tpfp_pkg::REG_IRQ_STAT, rd_v);
      check(rd_v[0], 1'b1);
      check(irq, 1'b0);
      rd(tpfp_pkg::REG_TS_RESETS, rd_v);
      check(rd_v, exp_rc);
      rd(tpfp_pkg::REG_TS_UPTIME, rd_v);
      check(rd_v, exp_up);
      rd(8'h20, rd_v);
      check(rd_v, 32'h0);
      @(posedge clk);
      hard_err  <= $urandom;
      safe_mode <= 1'b1;
      wr(tpfp_pkg::REG_CTRL, 32'h1);
      wr(tpfp_pkg::REG_CTRL, 32'h1);
      rd(tpfp_pkg::REG_STATUS, rd_v);
      check(rd_v[1:0], 2'b11);
      while (done_q !== 1'b1 && cyc < 29000) begin
         @(posedge clk);
         #1;
      end
      check(tx_valid, 1'b0);
      check(bit_cnt, 458);
      check(payload_type, tpfp_pkg::MAX_PAYLOAD_TYPE);
      rd(tpfp_pkg::REG_IRQ_STAT, rd_v);
      check(rd_v[2:1], 2'b11);
      for (int c = 0; c < 32; c++) check(frame_q[12*c +: 12], exp_max[c]);
      check(frame_q[384 +: 32], hard_err);
      check(frame_q[416 +: 16], exp_rc);
      check(frame_q[432 +: 25], exp_up);
      check(frame_q[457], 1'b1);
      wr(tpfp_pkg::REG_CTRL, 32'h2);
      rd(tpfp_pkg::REG_TS_RESETS, rd_v);
      check(rd_v, 32'h0);
      end_sim();
   end
endmodule // tb
